// file: rtl/flash_update_pkg.sv
// Shared constants for the data flash update link and its two ends
//
// Behaviour
// - Running scheme: host steps in fixed order
// - Data flash writes refused while protection active, except in ROM mode
// - Download keeps running but suppresses flash logging
// - Live status still updates during download
// - ROM scheme: host steps in fixed order
// - ROM mode halts conversion, monitoring, sequencing
// - Cleared checksum plus reset keeps ROM mode
// - Maker command clears checksum and resets
// - ROM mode answers only at address 11
// - No other target may use address 11
// - ROM mode: PEC required on writes, sent on reads
// - Normal program accepts PEC present or absent
// - Host erases whole segment before checksum rewrite
// - Full config assumes blank device, then resets
// - Host keeps config identifier in maker field
package flash_update_pkg;

	// --------------------------------------------------------------
	// Addresses and widths
	// --------------------------------------------------------------
	localparam logic [6:0] ROM_ADDR    = 7'h0b; // Fixed ROM-mode address, 11
	localparam logic [6:0] NORMAL_ADDR = 7'h20; // Default configured address
	localparam int         FLASH_DEPTH = 8;     // Data flash words

	// --------------------------------------------------------------
	// Command codes
	// --------------------------------------------------------------
	localparam logic [7:0] CMD_PART_ID   = 8'hfd; // part_identifier_read
	localparam logic [7:0] CMD_REVISION  = 8'h9b; // maker_revision_field
	localparam logic [7:0] CMD_STATUS    = 8'h7a; // output_voltage_status
	localparam logic [7:0] CMD_CLR_STAT  = 8'h03; // Clear live status
	localparam logic [7:0] CMD_PROTECT   = 8'h10; // Data 0 lifts protection
	localparam logic [7:0] CMD_RESET     = 8'hdb; // Soft reset
	localparam logic [7:0] CMD_ENTER_ROM = 8'hd9; // Clear checksum and reset
	localparam logic [7:0] CMD_DF_ERASE  = 8'he0; // Erase data flash
	localparam logic [7:0] CMD_DF_PTR    = 8'he1; // Rewind flash pointer
	localparam logic [7:0] CMD_DF_WRITE  = 8'he2; // Write word, advance
	localparam logic [7:0] CMD_DF_READ   = 8'he3; // Read word, advance
	localparam logic [7:0] CMD_LOG_ERASE = 8'he4; // Erase fault logs
	localparam logic [7:0] CMD_LOG_READ  = 8'he5; // Read log count
	localparam logic [7:0] CMD_SEG_ERASE = 8'hf0; // Erase checksum segment
	localparam logic [7:0] CMD_CK_WRITE  = 8'hf1; // Write program checksum
	localparam logic [7:0] CMD_CK_READ   = 8'hf2; // ROM-calculated checksum
	localparam logic [7:0] CMD_EXECUTE   = 8'hf3; // Run program from ROM

	// --------------------------------------------------------------
	// Reset values, identity and timing
	// --------------------------------------------------------------
	localparam logic [15:0] ERASED_WORD = 16'hffff; // Erased flash state
	localparam logic [15:0] PART_ID     = 16'h5a3c; // Arbitrary value
	localparam logic [15:0] REVISION    = 16'h0c01; // Arbitrary value
	localparam logic [15:0] PROG_SUM    = 16'h7e21; // Program image checksum
	localparam int          TIMEOUT_CYC = 16;       // Host answer wait

endpackage

// file: rtl/update_link_if.sv
// Transaction-level bus link between update host and target device
`timescale 1ns/1ns
`default_nettype none
interface update_link_if;
	logic        reqValid;  // One-cycle request strobe
	logic        reqWrite;  // 1 write, 0 read
	logic [6:0]  reqAddr;   // Target address
	logic [7:0]  reqCmd;    // Command code
	logic [15:0] reqData;   // Write data
	logic        reqPecOn;  // PEC byte present
	logic [7:0]  reqPec;    // PEC byte
	logic        respValid; // One-cycle answer strobe
	logic        respAck;   // 1 accepted, 0 refused
	logic [15:0] respData;  // Read data
	logic [7:0]  respPec;   // PEC over the answer

	modport host (output reqValid, reqWrite, reqAddr, reqCmd, reqData,
		reqPecOn, reqPec, input respValid, respAck, respData, respPec);
	modport device (input reqValid, reqWrite, reqAddr, reqCmd, reqData,
		reqPecOn, reqPec, output respValid, respAck, respData, respPec);
endinterface
`default_nettype wire

// file: rtl/pec_crc8.sv
// CRC-8 packet error code over a 32-bit frame, polynomial x^8+x^2+x+1
`timescale 1ns/1ns
`default_nettype none
module pec_crc8 (
	input  wire logic [31:0] frame, // Bytes sent most significant first
	output logic      [7:0]  pec    // Resulting check byte
);
	// --------------------------------------------------------------
	// Bitwise serial CRC, unrolled by the loop
	// --------------------------------------------------------------
	always_comb begin
		logic [7:0] c;
		c = 8'h00;
		for (int i = 31; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ frame[i]) ? 8'h07 : 8'h00);
		end
		pec = c;
	end
endmodule
`default_nettype wire

// file: rtl/flash_target.sv
// Target device end: command decoder, data flash, ROM mode and logging
`timescale 1ns/1ns
`default_nettype none
module flash_target #(
	parameter logic [6:0] OWN_ADDR = flash_update_pkg::NORMAL_ADDR,
	parameter int         DEPTH    = flash_update_pkg::FLASH_DEPTH
) (
	input  wire logic        clock,         // 50 MHz system clock
	input  wire logic        resetn,        // Synchronous, active low
	update_link_if.device    link,          // Bus side
	input  wire logic        faultEvent,    // One-cycle output fault
	input  wire logic        logEnable,     // Fault logging configured
	output logic             runActive,     // Conversion and sequencing on
	output logic             romActive,     // ROM mode
	output logic             writeProtect,  // Data flash protected
	output logic             downloading,   // Download in progress
	output logic      [7:0]  outputVoltageStatus, // Live status
	output logic      [7:0]  logCount       // Logged fault count
);
	import flash_update_pkg::*;

	localparam int PW = $clog2(DEPTH); // Pointer width

	// --------------------------------------------------------------
	// Storage and state
	// --------------------------------------------------------------
	logic [15:0]   flash [DEPTH]; // Data flash words
	logic [PW-1:0] ptr;           // Word pointer
	logic [15:0]   storedSum;     // Program checksum in flash
	logic [7:0]    reqPecCalc;    // Expected request PEC
	logic [7:0]    respPecCalc;   // PEC for the answer
	logic [15:0]   next_data;     // Answer data to register
	logic          next_ack;      // Accept decision
	logic          hit;           // Request addressed to us
	logic          pecGood;       // PEC rule satisfied
	logic          sumValid;      // Stored checksum matches program
	logic          cmdOk;         // Accepted request this cycle

	pec_crc8 reqCrc (
		.frame ({1'b0, link.reqAddr, link.reqCmd, link.reqData}),
		.pec   (reqPecCalc)
	);
	pec_crc8 respCrc (
		.frame ({1'b1, link.reqAddr, link.reqCmd, next_data}),
		.pec   (respPecCalc)
	);

	assign sumValid  = (storedSum == PROG_SUM);
	assign runActive = ~romActive;

	// --------------------------------------------------------------
	// Decode: address, PEC and command legality
	// --------------------------------------------------------------
	always_comb begin
		// ROM mode owns address 11 only
		hit = link.reqValid &&
			(romActive ? link.reqAddr == ROM_ADDR
			           : link.reqAddr == OWN_ADDR);
		// A bad PEC always fails; a missing one only on ROM-mode writes
		if (link.reqPecOn) begin
			pecGood = (link.reqPec == reqPecCalc);
		end else begin
			pecGood = !(romActive && link.reqWrite);
		end
		next_ack  = 1'b1;
		next_data = 16'h0000;
		case (link.reqCmd)
			CMD_PART_ID:   next_data = PART_ID;
			CMD_REVISION:  next_data = REVISION;
			CMD_STATUS:    next_data = {8'h00, outputVoltageStatus};
			CMD_DF_READ:   next_data = flash[ptr];
			CMD_LOG_READ:  next_data = {8'h00, logCount};
			CMD_CK_READ:   next_data = romActive ? PROG_SUM : 16'h0000;
			CMD_DF_ERASE, CMD_DF_WRITE: begin
				// Protection guards flash only while firmware runs
				next_ack = romActive || !writeProtect;
			end
			CMD_SEG_ERASE, CMD_CK_WRITE, CMD_EXECUTE: next_ack = romActive;
			CMD_CLR_STAT, CMD_PROTECT, CMD_RESET, CMD_DF_PTR,
			CMD_LOG_ERASE: next_ack = 1'b1;
			CMD_ENTER_ROM: next_ack = !romActive;
			default:       next_ack = 1'b0; // Unknown command refused
		endcase
		if (link.reqWrite == (link.reqCmd inside {CMD_PART_ID,
			CMD_REVISION, CMD_STATUS, CMD_DF_READ, CMD_LOG_READ,
			CMD_CK_READ})) begin
			next_ack = 1'b0; // Direction must suit the command
		end
		next_ack = next_ack && pecGood;
		// Refusals carry zero so the answer PEC covers what is sent
		if (!next_ack) begin
			next_data = 16'h0000;
		end
		cmdOk    = hit && next_ack;
	end

	// --------------------------------------------------------------
	// Answer path: one cycle after the request, registered
	// --------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!resetn) begin
			link.respValid <= 1'b0;
			link.respAck   <= 1'b0;
			link.respData  <= 16'h0000;
			link.respPec   <= 8'h00;
		end else begin
			link.respValid <= hit; // Silent when not addressed
			link.respAck   <= hit && next_ack;
			if (hit) begin
				link.respData <= next_data;
				link.respPec  <= respPecCalc;
			end
		end
	end

	// --------------------------------------------------------------
	// Mode, protection and download state
	// --------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!resetn) begin
			romActive    <= 1'b0;
			writeProtect <= 1'b1;
			downloading  <= 1'b0;
		end else if (cmdOk) begin
			case (link.reqCmd)
				CMD_PROTECT: begin
					writeProtect <= link.reqData[0];
				end
				CMD_DF_ERASE: begin
					downloading <= !romActive;
				end
				CMD_RESET: begin
					// Bad checksum keeps the part in ROM
					romActive    <= !sumValid;
					writeProtect <= 1'b1;
					downloading  <= 1'b0;
				end
				CMD_ENTER_ROM: begin
					// Checksum clear and reset done as one step
					romActive    <= 1'b1;
					writeProtect <= 1'b1;
					downloading  <= 1'b0;
				end
				CMD_EXECUTE: begin
					romActive <= !sumValid;
				end
				default: ;
			endcase
		end
	end

	// --------------------------------------------------------------
	// Program checksum held in program flash
	// --------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!resetn) begin
			storedSum <= PROG_SUM;
		end else if (cmdOk && link.reqCmd == CMD_ENTER_ROM) begin
			storedSum <= 16'h0000;
		end else if (cmdOk && link.reqCmd == CMD_SEG_ERASE) begin
			storedSum <= ERASED_WORD;
		end else if (cmdOk && link.reqCmd == CMD_CK_WRITE &&
			storedSum == ERASED_WORD) begin
			// Flash programs only from the erased state
			storedSum <= link.reqData;
		end
	end

	// --------------------------------------------------------------
	// Data flash pointer and array
	// --------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!resetn) begin
			ptr <= '0;
		end else if (cmdOk && link.reqCmd inside {CMD_DF_ERASE,
			CMD_DF_PTR}) begin
			ptr <= '0;
		end else if (cmdOk && link.reqCmd inside {CMD_DF_WRITE,
			CMD_DF_READ}) begin
			ptr <= PW'(ptr + 1'b1); // Wraps at the top
		end
	end

	for (genvar w = 0; w < DEPTH; w++) begin : g_word
		always_ff @(posedge clock) begin
			if (!resetn) begin
				flash[w] <= ERASED_WORD;
			end else if (cmdOk && link.reqCmd == CMD_DF_ERASE) begin
				flash[w] <= ERASED_WORD;
			end else if (cmdOk && link.reqCmd == CMD_DF_WRITE &&
				ptr == PW'(w)) begin
				flash[w] <= flash[w] & link.reqData; // Bits only clear
			end
		end
	end

	// --------------------------------------------------------------
	// Live status and fault log
	// --------------------------------------------------------------
	// Status keeps updating in a download; ROM ignores faults
	always_ff @(posedge clock) begin
		if (!resetn) begin
			outputVoltageStatus <= 8'h00;
		end else if (faultEvent && !romActive) begin
			outputVoltageStatus <= 8'h80;
		end else if (cmdOk && link.reqCmd == CMD_CLR_STAT) begin
			outputVoltageStatus <= 8'h00;
		end
	end

	// Logging would write flash, so it pauses during a download
	always_ff @(posedge clock) begin
		if (!resetn) begin
			logCount <= 8'h00;
		end else if (cmdOk && link.reqCmd == CMD_LOG_ERASE) begin
			logCount <= 8'h00;
		end else if (faultEvent && logEnable && !downloading &&
			!romActive && logCount != 8'hff) begin
			logCount <= logCount + 8'h01;
		end
	end
endmodule
`default_nettype wire

// file: rtl/flash_host.sv
// Host end: runs the running-mode or ROM-mode data flash update recipe
`timescale 1ns/1ns
`default_nettype none
module flash_host #(
	parameter logic [6:0] TARGET_ADDR = flash_update_pkg::NORMAL_ADDR,
	parameter int         DEPTH       = flash_update_pkg::FLASH_DEPTH
) (
	input  wire logic        clock,      // 50 MHz system clock
	input  wire logic        resetn,     // Synchronous, active low
	update_link_if.host      link,       // Bus side
	input  wire logic        start,      // One-cycle start pulse
	input  wire logic        romScheme,  // 1 selects ROM scheme
	input  wire logic        pecEnable,  // PEC in running mode
	input  wire logic [15:0] imageWord,  // Word at imageIndex
	output logic      [7:0]  imageIndex, // Word requested
	output logic             busy,       // Recipe running
	output logic             done,       // Recipe finished well
	output logic             fail        // Recipe stopped on error
);
	import flash_update_pkg::*;

	typedef enum {S_IDLE, S_PART, S_REV, S_UNPROT, S_ENROM, S_ERASE,
		S_WRITE, S_REWIND, S_VERIFY, S_SEGERASE, S_CKWRITE, S_CKREAD,
		S_EXEC, S_RESET, S_CHECK, S_LOGERASE} step_t;

	step_t       step;       // Current recipe step
	logic        waiting;    // Request out, answer pending
	logic        romPhase;   // Talking to the ROM address
	logic [4:0]  waitCount;  // Answer timeout
	logic        next_write; // Direction of the current step
	logic [7:0]  next_cmd;   // Command of the current step
	logic [15:0] next_data;  // Data of the current step
	logic [6:0]  next_addr;  // Address of the current step
	logic [7:0]  reqPecCalc; // PEC to send
	logic [7:0]  rspPecCalc; // PEC expected back
	logic        answerOk;   // Answer acked and consistent
	logic        lastWord;   // Final flash word reached

	assign next_addr = romPhase ? ROM_ADDR : TARGET_ADDR;
	assign lastWord  = (imageIndex == 8'(DEPTH - 1));

	pec_crc8 reqCrc (
		.frame ({1'b0, next_addr, next_cmd, next_data}),
		.pec   (reqPecCalc)
	);
	pec_crc8 rspCrc (
		.frame ({1'b1, next_addr, next_cmd, link.respData}),
		.pec   (rspPecCalc)
	);

	// --------------------------------------------------------------
	// Command of each step
	// --------------------------------------------------------------
	always_comb begin
		next_write = 1'b1;
		next_data  = 16'h0000;
		case (step)
			S_PART, S_CHECK: begin
				next_cmd   = CMD_PART_ID;
				next_write = 1'b0;
			end
			S_REV: begin
				next_cmd   = CMD_REVISION;
				next_write = 1'b0;
			end
			S_UNPROT:   next_cmd = CMD_PROTECT;
			S_ENROM:    next_cmd = CMD_ENTER_ROM;
			S_ERASE:    next_cmd = CMD_DF_ERASE;
			S_WRITE: begin
				next_cmd  = CMD_DF_WRITE;
				next_data = imageWord;
			end
			S_REWIND:   next_cmd = CMD_DF_PTR;
			S_VERIFY: begin
				next_cmd   = CMD_DF_READ;
				next_write = 1'b0;
			end
			S_SEGERASE: next_cmd = CMD_SEG_ERASE;
			S_CKWRITE: begin
				next_cmd  = CMD_CK_WRITE;
				next_data = PROG_SUM;
			end
			S_CKREAD: begin
				next_cmd   = CMD_CK_READ;
				next_write = 1'b0;
			end
			S_EXEC:     next_cmd = CMD_EXECUTE;
			S_RESET:    next_cmd = CMD_RESET;
			S_LOGERASE: next_cmd = CMD_LOG_ERASE;
			default:    next_cmd = 8'h00;
		endcase
	end

	// --------------------------------------------------------------
	// Answer check per step
	// --------------------------------------------------------------
	always_comb begin
		answerOk = link.respAck;
		if (romPhase && link.respPec != rspPecCalc) begin
			answerOk = 1'b0; // ROM always returns PEC
		end
		case (step)
			S_PART, S_CHECK: answerOk = answerOk &&
				link.respData == PART_ID;
			S_REV:    answerOk = answerOk && link.respData == REVISION;
			S_VERIFY: answerOk = answerOk && link.respData == imageWord;
			S_CKREAD: answerOk = answerOk && link.respData == PROG_SUM;
			default:  answerOk = answerOk;
		endcase
	end

	// --------------------------------------------------------------
	// Request drive
	// --------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!resetn) begin
			link.reqValid <= 1'b0;
			link.reqWrite <= 1'b0;
			link.reqAddr  <= 7'h00;
			link.reqCmd   <= 8'h00;
			link.reqData  <= 16'h0000;
			link.reqPecOn <= 1'b0;
			link.reqPec   <= 8'h00;
		end else begin
			link.reqValid <= busy && !waiting;
			if (busy && !waiting) begin
				link.reqWrite <= next_write;
				link.reqAddr  <= next_addr;
				link.reqCmd   <= next_cmd;
				link.reqData  <= next_data;
				link.reqPecOn <= romPhase || pecEnable;
				link.reqPec   <= reqPecCalc;
			end
		end
	end

	// --------------------------------------------------------------
	// Recipe sequencer
	// --------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!resetn) begin
			step       <= S_IDLE;
			busy       <= 1'b0;
			done       <= 1'b0;
			fail       <= 1'b0;
			waiting    <= 1'b0;
			romPhase   <= 1'b0;
			waitCount  <= 5'h00;
			imageIndex <= 8'h00;
		end else if (!busy) begin
			if (start) begin
				busy       <= 1'b1;
				done       <= 1'b0;
				fail       <= 1'b0;
				step       <= S_PART;
				romPhase   <= 1'b0;
				imageIndex <= 8'h00;
			end
		end else if (!waiting) begin
			waiting   <= 1'b1; // Request leaves this edge
			waitCount <= 5'h00;
		end else if (!link.respValid) begin
			waitCount <= waitCount + 5'h01;
			if (waitCount == 5'(TIMEOUT_CYC)) begin
				busy    <= 1'b0;
				fail    <= 1'b1;
				waiting <= 1'b0; // Next start must send again
			end
		end else if (!answerOk) begin
			busy    <= 1'b0;
			fail    <= 1'b1;
			waiting <= 1'b0;
		end else begin
			waiting <= 1'b0;
			case (step)
				S_PART:   step <= S_REV;
				S_REV:    step <= romScheme ? S_ENROM : S_UNPROT;
				S_UNPROT: step <= S_ERASE;
				S_ENROM: begin
					step     <= S_ERASE;
					romPhase <= 1'b1;
				end
				S_ERASE:  step <= S_WRITE;
				S_WRITE: begin
					imageIndex <= lastWord ? 8'h00 : imageIndex + 8'h01;
					step       <= lastWord ? S_REWIND : S_WRITE;
				end
				S_REWIND: step <= S_VERIFY;
				S_VERIFY: begin
					imageIndex <= imageIndex + 8'h01;
					if (lastWord) begin
						step <= romPhase ? S_SEGERASE : S_RESET;
					end
				end
				S_SEGERASE: step <= S_CKWRITE;
				S_CKWRITE:  step <= S_CKREAD;
				S_CKREAD:   step <= S_EXEC;
				S_EXEC: begin
					step     <= S_CHECK;
					romPhase <= 1'b0;
				end
				S_RESET:    step <= S_CHECK;
				S_CHECK:    step <= S_LOGERASE;
				S_LOGERASE: begin
					step <= S_IDLE;
					busy <= 1'b0;
					done <= 1'b1;
				end
				default: begin
					step <= S_IDLE;
					busy <= 1'b0;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// file: tb/flash_update_chk.sv
// Concurrent checks on the link between update host and target
`timescale 1ns/1ns
`default_nettype none
module flash_update_chk (
	input wire logic        clock,     // System clock
	input wire logic        resetn,    // Synchronous, active low
	input wire logic        reqValid,  // Request strobe
	input wire logic        reqWrite,  // Direction
	input wire logic [6:0]  reqAddr,   // Target address
	input wire logic [7:0]  reqCmd,    // Command code
	input wire logic [15:0] reqData,   // Write data
	input wire logic        reqPecOn,  // Check byte present
	input wire logic [7:0]  reqPec,    // Check byte
	input wire logic        respValid, // Answer strobe
	input wire logic        respAck,   // Accepted
	input wire logic [15:0] respData,  // Read data
	input wire logic [7:0]  respPec    // Answer check byte
);
	import flash_update_pkg::*;

	// ------------------------------------------------------------
	// Check byte model
	// ------------------------------------------------------------
	// Own CRC so a wrong polynomial in the design cannot hide
	function automatic logic [7:0] crc8(input logic [31:0] f);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 31; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ f[i]) ? 8'h07 : 8'h00);
		end
		return c;
	endfunction

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);

	a_answer_next_cycle: assert property (reqValid |=> respValid)
		else $error("no answer");
	a_no_spare_answer: assert property (respValid |-> $past(reqValid))
		else $error("spare answer");
	a_rom_write_pec: assert property (reqValid && reqWrite &&
		reqAddr == ROM_ADDR |-> reqPecOn)
		else $error("ROM write lacks PEC");
	a_req_pec_good: assert property (reqValid && reqPecOn |->
		reqPec == crc8({1'b0, reqAddr, reqCmd, reqData}))
		else $error("bad request PEC");
	a_resp_pec_sent: assert property (respValid |-> respPec ==
		crc8({1'b1, $past(reqAddr), $past(reqCmd), respData}))
		else $error("bad answer PEC");
	a_part_id_read: assert property (reqValid && !reqWrite &&
		reqCmd == CMD_PART_ID |=> respAck && respData == PART_ID)
		else $error("bad part id");
	a_rom_sum_match: assert property (reqValid && !reqWrite &&
		reqCmd == CMD_CK_READ |=> respAck && respData == PROG_SUM)
		else $error("bad checksum");
	a_recipe_all_acked: assert property (respValid |-> respAck)
		else $error("step refused");
endmodule
`default_nettype wire

// file: tb/test_data_flash_update_sequencer.sv
// Bench for host and target ends plus a directly driven second target
`timescale 1ns/1ns
`default_nettype none
module test_data_flash_update_sequencer;
	import flash_update_pkg::*;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic        clock, resetn, start, romScheme, pecEnable;
	logic        faultEvent, logEnable, busy, done, fail;
	logic        runActive, romActive, writeProtect, downloading;
	logic [7:0]  status, logCount, imageIndex;
	logic [15:0] image [FLASH_DEPTH]; // Image served to host
	logic        bRom;                // Second target ROM mode
	logic [15:0] lastData, d;         // Last read word, scratch
	int          mismatches, samples_checked, cycles, seed;

	update_link_if linkA ();
	update_link_if linkB (); // Bench drives this one to break rules

	flash_host u_flash_host (.clock(clock), .resetn(resetn), .link(linkA),
		.start(start), .romScheme(romScheme), .pecEnable(pecEnable),
		.imageWord(image[imageIndex[2:0]]), .imageIndex(imageIndex),
		.busy(busy), .done(done), .fail(fail));
	flash_target u_flash_target (.clock(clock), .resetn(resetn),
		.link(linkA), .faultEvent(faultEvent), .logEnable(logEnable),
		.runActive(runActive), .romActive(romActive),
		.writeProtect(writeProtect), .downloading(downloading),
		.outputVoltageStatus(status), .logCount(logCount));
	flash_target u_flash_target_b (.clock(clock), .resetn(resetn),
		.link(linkB), .faultEvent(1'b0), .logEnable(1'b0),
		.runActive(), .romActive(bRom), .writeProtect(),
		.downloading(), .outputVoltageStatus(), .logCount());
	flash_update_chk u_flash_update_chk (.clock(clock), .resetn(resetn),
		.reqValid(linkA.reqValid), .reqWrite(linkA.reqWrite),
		.reqAddr(linkA.reqAddr), .reqCmd(linkA.reqCmd),
		.reqData(linkA.reqData), .reqPecOn(linkA.reqPecOn),
		.reqPec(linkA.reqPec), .respValid(linkA.respValid),
		.respAck(linkA.respAck), .respData(linkA.respData),
		.respPec(linkA.respPec));

	// ------------------------------------------------------------
	// Clock, timeout and helpers
	// ------------------------------------------------------------
	always #10 clock = ~clock;

	// Hang guard, far above the few hundred cycles needed
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			complete_run();
		end
	end

	function automatic logic [7:0] crc8(input logic [31:0] f);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 31; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ f[i]) ? 8'h07 : 8'h00);
		end
		return c;
	endfunction

	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check1(input string what, input logic exp, got);
		check(what, {15'h0, exp}, {15'h0, got});
	endtask

	task automatic wait_end();
		for (int k = 0; k < 2000 && done !== 1'b1 && fail !== 1'b1; k++)
			@(posedge clock);
		#1;
	endtask

	// Fault pulse into first target
	task automatic pulse_fault();
		@(posedge clock) #1 faultEvent = 1'b1;
		@(posedge clock) #1 faultEvent = 1'b0;
	endtask

	// Request on the second link; bad flips bit 0 of the check byte
	task automatic xfer(input logic w, input logic [6:0] a,
		input logic [7:0] c, input logic [15:0] dat, input logic p,
		input logic bad, input logic ea, input logic nr);
		@(posedge clock) #1;
		{linkB.reqWrite, linkB.reqAddr, linkB.reqCmd} = {w, a, c};
		{linkB.reqData, linkB.reqPecOn} = {dat, p};
		linkB.reqPec = crc8({1'b0, a, c, dat}) ^ {7'h00, bad};
		linkB.reqValid = 1'b1;
		@(posedge clock) #1;
		linkB.reqValid = 1'b0;
		linkB.reqData = ~dat; // Released lines do not keep old value
		check1("answer", !nr, linkB.respValid);
		if (!nr) begin
			check1("ack", ea, linkB.respAck);
			lastData = linkB.respData;
			check("pec", {8'h0, crc8({1'b1, a, c, lastData})},
				{8'h0, linkB.respPec});
		end
	endtask

	task automatic run_host(input logic rom);
		for (int i = 0; i < FLASH_DEPTH; i++) image[i] = $random(seed);
		romScheme = rom;
		pecEnable = $random(seed);
		@(posedge clock) #1 start = 1'b1;
		@(posedge clock) #1 start = 1'b0;
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{clock, resetn, start, romScheme, pecEnable} = 5'b0;
		{faultEvent, logEnable, mismatches, samples_checked} = '0;
		{linkB.reqValid, linkB.reqWrite, linkB.reqAddr} = '0;
		{linkB.reqCmd, linkB.reqData, linkB.reqPecOn, linkB.reqPec} = '0;
		{cycles, lastData, d, seed} = {32'h0, 16'h0, 16'h0, 32'he6a6};
		repeat (12) @(posedge clock);
		#1 resetn = 1'b1;
		// Running scheme with logging on and a fault mid download
		logEnable = 1'b1;
		pulse_fault();
		check("log before", 16'h1, {8'h0, logCount});
		run_host(1'b0);
		for (int k = 0; k < 500 && downloading !== 1'b1; k++) @(posedge clock);
		pulse_fault();
		check("log in download", 16'h1, {8'h0, logCount});
		check1("live status", 1'b1, status[7]);
		wait_end();
		check1("run done", 1'b1, done);
		check("log erased", 16'h0, {8'h0, logCount});
		$display("test running scheme ended");
		// ROM scheme; faults in ROM mode must not log
		run_host(1'b1);
		for (int k = 0; k < 500 && romActive !== 1'b1; k++) @(posedge clock);
		#1 check1("rom halts run", 1'b0, runActive);
		pulse_fault();
		check("rom log", 16'h0, {8'h0, logCount});
		wait_end();
		check1("rom done", 1'b1, done);
		check1("rom left", 1'b0, romActive);
		$display("test ROM scheme ended");
		// Second target driven directly, rule breaks included
		d = $random(seed);
		xfer(1, NORMAL_ADDR, CMD_DF_ERASE, 0, 0, 0, 0, 0);
		xfer(1, NORMAL_ADDR, CMD_PROTECT, 0, 1, 1, 0, 0);
		xfer(1, NORMAL_ADDR, CMD_PROTECT, 0, 0, 0, 1, 0);
		xfer(1, NORMAL_ADDR, CMD_DF_ERASE, 0, 1, 0, 1, 0);
		xfer(1, NORMAL_ADDR, CMD_DF_WRITE, d, 0, 0, 1, 0);
		xfer(1, NORMAL_ADDR, CMD_DF_PTR, 0, 0, 0, 1, 0);
		xfer(0, NORMAL_ADDR, CMD_DF_READ, 0, 0, 0, 1, 0);
		check("flash word", d, lastData);
		xfer(1, NORMAL_ADDR, CMD_ENTER_ROM, 0, 0, 0, 1, 0);
		check1("rom entered", 1'b1, bRom);
		xfer(0, NORMAL_ADDR, CMD_PART_ID, 0, 0, 0, 0, 1);
		xfer(1, ROM_ADDR, CMD_DF_PTR, 0, 0, 0, 0, 0);
		xfer(1, ROM_ADDR, CMD_RESET, 0, 1, 0, 1, 0);
		check1("rom kept", 1'b1, bRom);
		xfer(1, ROM_ADDR, CMD_SEG_ERASE, 0, 1, 0, 1, 0);
		xfer(1, ROM_ADDR, CMD_CK_WRITE, PROG_SUM, 1, 0, 1, 0);
		xfer(0, ROM_ADDR, CMD_CK_READ, 0, 0, 0, 1, 0);
		check("checksum", PROG_SUM, lastData);
		xfer(1, ROM_ADDR, CMD_EXECUTE, 0, 1, 0, 1, 0);
		check1("rom exit", 1'b0, bRom);
		xfer(0, NORMAL_ADDR, CMD_PART_ID, 0, 0, 0, 1, 0);
		check("part id", PART_ID, lastData);
		$display("test direct target ended");
		complete_run();
	end
endmodule
`default_nettype wire
